// *** common/secure_host_pkg.sv ***
`default_nettype none
package secure_host_pkg;
   // ****************************************************************
   // Command sequence addresses and data
   // ****************************************************************
   localparam logic [11:0] UNLOCK1_WORD_ADDR = 12'h555;
   localparam logic [11:0] UNLOCK2_WORD_ADDR = 12'h2aa;
   localparam logic [11:0] UNLOCK1_BYTE_ADDR = 12'haaa;
   localparam logic [11:0] UNLOCK2_BYTE_ADDR = 12'h555;
   localparam logic [15:0] UNLOCK1_DATA      = 16'h00aa;
   localparam logic [15:0] UNLOCK2_DATA      = 16'h0055;
   localparam logic [15:0] ENTRY_DATA        = 16'h0088;
   localparam logic [15:0] EXIT3_DATA        = 16'h0090;
   localparam logic [15:0] EXIT4_DATA        = 16'h0000;
   localparam logic [15:0] PROGRAM_DATA      = 16'h00a0;
   // ****************************************************************
   // Secure sector layout and indicator
   // ****************************************************************
   localparam int          SECURE_WORDS      = 128;
   localparam logic [7:0]  SERIAL_FIRST_ADDR = 8'h00;
   localparam logic [7:0]  SERIAL_LAST_ADDR  = 8'h07;
   localparam int          LOCK_BIT_POS      = 7;
   // ****************************************************************
   // Bus cycle timing
   // ****************************************************************
   localparam int          WE_LOW_NS         = 40;
   localparam int          CLK_PERIOD_NS     = 4;
   localparam logic [7:0]  WE_LOW_CYCLES     =
      8'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0]  WE_HIGH_CYCLES    = 8'h04;
   localparam logic [7:0]  READ_CYCLES       = 8'h19;
   // ****************************************************************
   // Commands and pin groups
   // ****************************************************************
   typedef enum logic [2:0] {
      CMD_READ    = 3'b000,
      CMD_ENTER   = 3'b001,
      CMD_EXIT    = 3'b010,
      CMD_PROGRAM = 3'b011,
      CMD_RESET   = 3'b100
   } command_type;
   typedef struct packed {
      logic        write_en;
      logic        read_en;
      logic [23:0] addr;
      logic [15:0] wdata;
   } bus_cycle_type;
   typedef struct packed {
      logic        chip_en_n;
      logic        write_en_n;
      logic        out_en_n;
      logic        reset_n;
      logic [23:0] addr;
      logic [15:0] dq_out;
      logic        dq_oe;
   } flash_pins_type;
endpackage : secure_host_pkg
`default_nettype wire

// *** rtl/flash_bus_cycle.sv ***
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle (
   input  wire logic                           sys_clk_i,
   input  wire logic                           rst_n_i,
   input  wire secure_host_pkg::bus_cycle_type cycle_i,
   input  wire logic [15:0]                    dq_in_i,
   output logic                                busy_o,
   output logic                                done_o,
   output logic [15:0]                         rdata_o,
   output secure_host_pkg::flash_pins_type     pins_o
);
   // ****************************************************************
   // One asynchronous write or read cycle on the flash pins
   // ****************************************************************
   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ  = 2'b10,
      PH_GAP   = 2'b11
   } phase_type;

   phase_type    phase_reg;
   phase_type    phase_next;
   logic [7:0]   count_reg;
   logic [7:0]   count_next;
   logic         start_w;
   logic         count_zero_w;

   assign start_w      = (phase_reg == PH_IDLE) &&
                         (cycle_i.write_en || cycle_i.read_en);
   assign count_zero_w = (count_reg == 8'h00);

   always_comb begin
      phase_next = phase_reg;
      count_next = count_zero_w ? 8'h00 : count_reg - 8'h01;
      unique case (phase_reg)
         PH_IDLE: begin
            if (cycle_i.write_en) begin
               phase_next = PH_WRITE;
               count_next = secure_host_pkg::WE_LOW_CYCLES;
            end else if (cycle_i.read_en) begin
               phase_next = PH_READ;
               count_next = secure_host_pkg::READ_CYCLES;
            end
         end
         PH_WRITE, PH_READ: begin
            if (count_zero_w) begin
               phase_next = PH_GAP;
               count_next = secure_host_pkg::WE_HIGH_CYCLES;
            end
         end
         PH_GAP: begin
            if (count_zero_w) begin
               phase_next = PH_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_reg         <= PH_IDLE;
         count_reg         <= 8'h00;
         busy_o            <= 1'b0;
         done_o            <= 1'b0;
         rdata_o           <= 16'h0000;
         pins_o.chip_en_n  <= 1'b1;
         pins_o.write_en_n <= 1'b1;
         pins_o.out_en_n   <= 1'b1;
         pins_o.reset_n    <= 1'b0;
         pins_o.addr       <= 24'h000000;
         pins_o.dq_out     <= 16'h0000;
         pins_o.dq_oe      <= 1'b0;
      end else begin
         phase_reg         <= phase_next;
         count_reg         <= count_next;
         pins_o.reset_n    <= 1'b1;
         busy_o            <= (phase_next != PH_IDLE);
         done_o            <= (phase_reg == PH_GAP) && count_zero_w;
         if (start_w) begin
            pins_o.addr   <= cycle_i.addr;
            pins_o.dq_out <= cycle_i.wdata;
         end
         pins_o.chip_en_n  <= !((phase_next == PH_WRITE) ||
                                (phase_next == PH_READ));
         pins_o.write_en_n <= (phase_next != PH_WRITE);
         pins_o.dq_oe      <= (phase_next == PH_WRITE);
         pins_o.out_en_n   <= (phase_next != PH_READ);
         if ((phase_reg == PH_READ) && count_zero_w) begin
            rdata_o <= dq_in_i;
         end
      end
   end
endmodule // flash_bus_cycle
`default_nettype wire

// *** rtl/secure_sector_host.sv ***
// What this block does
// - After program, host polls device busy until clear, then finishes; exit is a separate command
// - Entry: AA@555, 55@2AA, 88@555 (word)
// - Exit: unlocks, 90@555, then 00 anywhere
// - Program: unlocks, A0@555, then data word
`timescale 1ns/1ns
`default_nettype none
module secure_sector_host #(
   parameter int unsigned  ADDR_W    = 24,
   parameter logic [23:0]  BASE_ADDR = 24'h000000
) (
   input  wire logic                          sys_clk_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          cmd_valid_i,
   input  wire secure_host_pkg::command_type  cmd_i,
   input  wire logic [6:0]                    cmd_offset_i,
   input  wire logic [15:0]                   cmd_wdata_i,
   input  wire logic                          byte_mode_i,
   input  wire logic                          factory_locked_i,
   input  wire logic                          device_busy_i,
   input  wire logic [15:0]                   dq_in_i,
   output logic                               cmd_ready_o,
   output logic                               cmd_done_o,
   output logic                               cmd_error_o,
   output logic [15:0]                        rdata_o,
   output logic                               secure_mode_o,
   output logic                               lock_indicator_bit_o,
   output logic                               accel_allowed_o,
   output secure_host_pkg::flash_pins_type    pins_o
);
   // ****************************************************************
   // Sequence state
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_STEP   = 3'b001,
      ST_WAIT   = 3'b010,
      ST_POLL   = 3'b011,
      ST_FINISH = 3'b100
   } state_type;

   function automatic logic [23:0] word_addr(input logic [11:0] w,
                                              input logic [11:0] b,
                                              input logic bm);
      word_addr = BASE_ADDR + {12'h000, (bm ? b : w)};
   endfunction

   state_type                        state_reg;
   state_type                        state_next;
   secure_host_pkg::command_type     cmd_reg;
   logic [1:0]                       step_reg;
   logic [6:0]                       offset_reg;
   logic [15:0]                      wdata_reg;
   logic                             secure_reg;
   logic                             bm_reg;
   logic                             error_reg;
   logic [15:0]                      rdata_reg;
   secure_host_pkg::bus_cycle_type   cycle_w;
   logic                             done_w;
   logic [15:0]                      bus_rdata_w;
   secure_host_pkg::flash_pins_type  pins_w;
   logic                             refuse_w;
   logic                             last_step_w;
   logic                             read_cmd_w;
   logic [23:0]                      target_w;

   // ****************************************************************
   // Command acceptance
   // ****************************************************************
   assign refuse_w =
      (cmd_i == secure_host_pkg::CMD_PROGRAM &&
       (!secure_reg || factory_locked_i)) ||
      (cmd_i == secure_host_pkg::CMD_ENTER && secure_reg) ||
      (cmd_i == secure_host_pkg::CMD_EXIT && !secure_reg) ||
      device_busy_i;
   assign read_cmd_w  = (cmd_reg == secure_host_pkg::CMD_READ) ||
                        (cmd_reg == secure_host_pkg::CMD_RESET);
   assign last_step_w = read_cmd_w ||
                        (cmd_reg == secure_host_pkg::CMD_ENTER &&
                         step_reg == 2'd2) ||
                        (step_reg == 2'd3);
   // Secure words overlay the first sector at the base
   assign target_w = BASE_ADDR +
                     {17'h00000, offset_reg};

   // ****************************************************************
   // Address and data of the current write or read
   // ****************************************************************
   always_comb begin
      cycle_w          = '0;
      cycle_w.write_en = (state_reg == ST_STEP) && !read_cmd_w;
      cycle_w.read_en  = (state_reg == ST_STEP) && read_cmd_w;
      cycle_w.addr     = target_w;
      cycle_w.wdata    = wdata_reg;
      unique case (step_reg)
         2'd0: begin
            cycle_w.addr  = word_addr(secure_host_pkg::UNLOCK1_WORD_ADDR,
                                      secure_host_pkg::UNLOCK1_BYTE_ADDR,
                                      bm_reg);
            cycle_w.wdata = secure_host_pkg::UNLOCK1_DATA;
         end
         2'd1: begin
            cycle_w.addr  = word_addr(secure_host_pkg::UNLOCK2_WORD_ADDR,
                                      secure_host_pkg::UNLOCK2_BYTE_ADDR,
                                      bm_reg);
            cycle_w.wdata = secure_host_pkg::UNLOCK2_DATA;
         end
         2'd2: begin
            cycle_w.addr = word_addr(secure_host_pkg::UNLOCK1_WORD_ADDR,
                                     secure_host_pkg::UNLOCK1_BYTE_ADDR,
                                     bm_reg);
            unique case (cmd_reg)
               secure_host_pkg::CMD_ENTER:
                  cycle_w.wdata = secure_host_pkg::ENTRY_DATA;
               secure_host_pkg::CMD_EXIT:
                  cycle_w.wdata = secure_host_pkg::EXIT3_DATA;
               default:
                  cycle_w.wdata = secure_host_pkg::PROGRAM_DATA;
            endcase
         end
         2'd3: begin
            cycle_w.addr  = target_w;
            cycle_w.wdata = (cmd_reg == secure_host_pkg::CMD_EXIT) ?
                            secure_host_pkg::EXIT4_DATA : wdata_reg;
         end
      endcase
      if (read_cmd_w) begin
         cycle_w.addr = target_w;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:   if (cmd_valid_i) state_next = ST_STEP;
         ST_STEP:   state_next = ST_WAIT;
         ST_WAIT: begin
            if (done_w) begin
               if (!last_step_w) begin
                  state_next = ST_STEP;
               end else if (cmd_reg == secure_host_pkg::CMD_PROGRAM) begin
                  state_next = ST_POLL;
               end else begin
                  state_next = ST_FINISH;
               end
            end
         end
         ST_POLL:   if (!device_busy_i) state_next = ST_FINISH;
         ST_FINISH: state_next = ST_IDLE;
         default:   state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg  <= ST_IDLE;
         cmd_reg    <= secure_host_pkg::CMD_READ;
         step_reg   <= 2'd0;
         offset_reg <= 7'h00;
         wdata_reg  <= 16'h0000;
         secure_reg <= 1'b0;
         bm_reg     <= 1'b0;
         error_reg  <= 1'b0;
         rdata_reg  <= 16'h0000;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_IDLE && cmd_valid_i) begin
            cmd_reg    <= cmd_i;
            offset_reg <= cmd_offset_i;
            wdata_reg  <= cmd_wdata_i;
            bm_reg     <= byte_mode_i;
            step_reg   <= 2'd0;
            error_reg  <= refuse_w;
            if (refuse_w) begin
               state_reg <= ST_FINISH;
            end
            if (cmd_i == secure_host_pkg::CMD_RESET) begin
               secure_reg <= 1'b0;
            end
         end
         if (state_reg == ST_WAIT && done_w) begin
            step_reg <= step_reg + 2'd1;
            if (read_cmd_w) begin
               rdata_reg <= bus_rdata_w;
            end
            if (last_step_w && cmd_reg == secure_host_pkg::CMD_ENTER) begin
               secure_reg <= 1'b1;
            end
            if (last_step_w && cmd_reg == secure_host_pkg::CMD_EXIT) begin
               secure_reg <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_ready_o          <= 1'b0;
         cmd_done_o           <= 1'b0;
         cmd_error_o          <= 1'b0;
         rdata_o              <= 16'h0000;
         secure_mode_o        <= 1'b0;
         lock_indicator_bit_o <= 1'b0;
         accel_allowed_o      <= 1'b0;
      end else begin
         cmd_ready_o          <= (state_next == ST_IDLE);
         cmd_done_o           <= (state_reg == ST_FINISH);
         cmd_error_o          <= (state_reg == ST_FINISH) && error_reg;
         rdata_o              <= rdata_reg;
         secure_mode_o        <= secure_reg;
         lock_indicator_bit_o <= factory_locked_i;
         accel_allowed_o      <= !secure_reg;
      end
   end

   assign pins_o = pins_w;

   flash_bus_cycle u_bus (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .cycle_i   (cycle_w),
      .dq_in_i   (dq_in_i),
      .busy_o    (),
      .done_o    (done_w),
      .rdata_o   (bus_rdata_w),
      .pins_o    (pins_w)
   );
endmodule // secure_sector_host
`default_nettype wire

// *** sim/secure_sector_host_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module secure_sector_host_monitor (
   input wire logic                            sys_clk_i,
   input wire logic                            rst_n_i,
   input wire logic                            cmd_valid_i,
   input wire secure_host_pkg::command_type    cmd_i,
   input wire logic [6:0]                      cmd_offset_i,
   input wire logic [15:0]                     cmd_wdata_i,
   input wire logic                            byte_mode_i,
   input wire logic                            factory_locked_i,
   input wire logic                            device_busy_i,
   input wire logic [15:0]                     dq_in_i,
   input wire logic                            cmd_ready_o,
   input wire logic                            cmd_done_o,
   input wire logic                            cmd_error_o,
   input wire logic [15:0]                     rdata_o,
   input wire logic                            secure_mode_o,
   input wire logic                            lock_indicator_bit_o,
   input wire logic                            accel_allowed_o,
   input wire secure_host_pkg::flash_pins_type pins_o
);
   // ****
   // Checks
   // ****
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic take = cmd_valid_i && cmd_ready_o;
   wire logic is_prog = cmd_i == secure_host_pkg::CMD_PROGRAM;
   wire logic is_ent = cmd_i == secure_host_pkg::CMD_ENTER;
   wire logic is_ext = cmd_i == secure_host_pkg::CMD_EXIT;
   property p_err_done; cmd_error_o |-> cmd_done_o; endproperty
   a_err_done: assert property (p_err_done)
      else $error("error flag without done");
   property p_busy_ref;
      take && device_busy_i |-> ##[1:2] (cmd_done_o && cmd_error_o);
   endproperty
   a_busy_ref: assert property (p_busy_ref)
      else $error("request while busy not refused");
   property p_busy_pins;
      take && device_busy_i |-> pins_o.write_en_n [*3];
   endproperty
   a_busy_pins: assert property (p_busy_pins)
      else $error("write strobe while busy");
   property p_prog_ref;
      take && is_prog && (!secure_mode_o || factory_locked_i)
         |-> ##[1:2] cmd_error_o;
   endproperty
   a_prog_ref: assert property (p_prog_ref)
      else $error("program not refused");
   property p_enter_ref;
      take && is_ent && secure_mode_o |-> ##[1:2] cmd_error_o;
   endproperty
   a_enter_ref: assert property (p_enter_ref)
      else $error("second entry not refused");
   property p_exit_ref;
      take && is_ext && !secure_mode_o |-> ##[1:2] cmd_error_o;
   endproperty
   a_exit_ref: assert property (p_exit_ref)
      else $error("exit outside secure mode not refused");
   property p_accel; secure_mode_o |-> !accel_allowed_o; endproperty
   a_accel: assert property (p_accel)
      else $error("accelerated program allowed in secure mode");
   property p_lock;
      $past(rst_n_i) |-> lock_indicator_bit_o == $past(factory_locked_i);
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock indicator does not follow variant");
   property p_hold;
      cmd_ready_o && !cmd_valid_i |=> $stable(secure_mode_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("mode changed while idle");
   property p_wr_cyc;
      !pins_o.write_en_n |-> !pins_o.chip_en_n && pins_o.dq_oe
         && pins_o.out_en_n;
   endproperty
   a_wr_cyc: assert property (p_wr_cyc)
      else $error("write strobe without select and data");
   property p_we_len;
      $fell(pins_o.write_en_n) |-> !pins_o.write_en_n [*8];
   endproperty
   a_we_len: assert property (p_we_len)
      else $error("write strobe too short");
endmodule // secure_sector_host_monitor
bind secure_sector_host secure_sector_host_monitor i_mon (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
   .cmd_i(cmd_i), .cmd_offset_i(cmd_offset_i), .cmd_wdata_i(cmd_wdata_i),
   .byte_mode_i(byte_mode_i), .factory_locked_i(factory_locked_i),
   .device_busy_i(device_busy_i), .dq_in_i(dq_in_i),
   .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
   .cmd_error_o(cmd_error_o), .rdata_o(rdata_o),
   .secure_mode_o(secure_mode_o),
   .lock_indicator_bit_o(lock_indicator_bit_o),
   .accel_allowed_o(accel_allowed_o), .pins_o(pins_o));
`default_nettype wire

// *** sim/flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module flash_model (
   input  wire logic                            clk_i,
   input  wire secure_host_pkg::flash_pins_type pins_i,
   input  wire logic                            byte_mode_i,
   input  wire logic                            factory_locked_i,
   output logic [15:0]                          dq_o,
   output logic                                 busy_o
);
   // ****
   // Device behaviour
   // ****
   secure_host_pkg::flash_pins_type p_q;
   logic [15:0] mem [0:127];
   logic [15:0] last_q;
   logic [2:0]  step_q;
   logic        sec_q;
   logic [4:0]  busy_cnt;
   wire logic [11:0] a = p_q.addr[11:0];
   wire logic [15:0] d = p_q.dq_out;
   wire logic [11:0] u1 = byte_mode_i ? secure_host_pkg::UNLOCK1_BYTE_ADDR
                                      : secure_host_pkg::UNLOCK1_WORD_ADDR;
   wire logic [11:0] u2 = byte_mode_i ? secure_host_pkg::UNLOCK2_BYTE_ADDR
                                      : secure_host_pkg::UNLOCK2_WORD_ADDR;
   wire logic wr = pins_i.write_en_n && !p_q.write_en_n && !p_q.chip_en_n;
   wire logic rd = !pins_i.chip_en_n && !pins_i.out_en_n;
   wire logic in_sec = sec_q && pins_i.addr[23:16] == 8'h00;
   wire logic in_rng = pins_i.addr[15:7] == 9'h000;
   assign dq_o = !rd ? ~last_q : !in_sec ? pins_i.addr[15:0] ^ 16'h5a5a
               : in_rng ? mem[pins_i.addr[6:0]] : ~last_q;
   assign busy_o = busy_cnt != 5'h00;
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = (i < 8) ? 16'hc000 | 16'(i) : 16'hffff;
      end
   end
   always @(posedge clk_i) begin
      p_q <= pins_i;
      last_q <= dq_o;
      if (busy_cnt != 5'h00) busy_cnt <= busy_cnt - 5'h01;
      if (!pins_i.reset_n) begin
         sec_q <= 1'b0;
         step_q <= 3'h0;
         busy_cnt <= 5'h00;
      end else if (wr && busy_cnt == 5'h00) begin
         step_q <= 3'h0;
         if (step_q == 3'h0 && a == u1 && d == secure_host_pkg::UNLOCK1_DATA)
            step_q <= 3'h1;
         if (step_q == 3'h1 && a == u2 && d == secure_host_pkg::UNLOCK2_DATA)
            step_q <= 3'h2;
         if (step_q == 3'h2 && a == u1) begin
            if (d == secure_host_pkg::ENTRY_DATA) sec_q <= 1'b1;
            if (d == secure_host_pkg::EXIT3_DATA) step_q <= 3'h3;
            if (d == secure_host_pkg::PROGRAM_DATA) step_q <= 3'h4;
         end
         if (step_q == 3'h3 && d == secure_host_pkg::EXIT4_DATA)
            sec_q <= 1'b0;
         if (step_q == 3'h4) begin
            busy_cnt <= 5'h14;
            if (sec_q && !factory_locked_i && p_q.addr[23:7] == 17'h0)
               mem[p_q.addr[6:0]] <= mem[p_q.addr[6:0]] & d;
         end
      end
   end
endmodule // flash_model
`default_nettype wire

// *** sim/secure_sector_host_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module secure_sector_host_bench;
   logic sys_clk_i, rst_n_i, cmd_valid_i, byte_mode_i, factory_locked_i;
   logic tb_busy, dev_busy, cmd_ready_o, cmd_done_o, cmd_error_o, err_q;
   logic secure_mode_o, lock_indicator_bit_o, accel_allowed_o;
   logic [6:0]                      cmd_offset_i;
   logic [15:0]                     cmd_wdata_i, dq_in_i, rdata_o;
   secure_host_pkg::command_type    cmd_i;
   secure_host_pkg::flash_pins_type pins_o;
   int                              n_mismatch, tests_run;
   secure_sector_host i_dut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .cmd_offset_i(cmd_offset_i), .cmd_wdata_i(cmd_wdata_i),
      .byte_mode_i(byte_mode_i), .factory_locked_i(factory_locked_i),
      .device_busy_i(tb_busy | dev_busy), .dq_in_i(dq_in_i),
      .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
      .cmd_error_o(cmd_error_o), .rdata_o(rdata_o),
      .secure_mode_o(secure_mode_o),
      .lock_indicator_bit_o(lock_indicator_bit_o),
      .accel_allowed_o(accel_allowed_o), .pins_o(pins_o));
   flash_model i_model (
      .clk_i(sys_clk_i), .pins_i(pins_o), .byte_mode_i(byte_mode_i),
      .factory_locked_i(factory_locked_i), .dq_o(dq_in_i),
      .busy_o(dev_busy));
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   // ****
   // Shared tasks
   // ****
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
         n_mismatch++;
      end
   endtask
   task automatic run(input secure_host_pkg::command_type c,
                      input logic [6:0] off, input logic [15:0] wd);
      int i;
      i = 0;
      while (cmd_ready_o !== 1'b1 && i < 4000) begin
         @(posedge sys_clk_i);
         #1 i++;
      end
      if (i >= 4000) i = 8000;
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_i <= c;
      cmd_offset_i <= off;
      cmd_wdata_i <= wd;
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
      do begin
         @(posedge sys_clk_i);
         #1 i++;
      end while (cmd_done_o !== 1'b1 && i < 8000);
      if (i >= 8000) begin
         n_mismatch++;
         end_sim();
      end
      err_q = cmd_error_o;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_enter();
      run(secure_host_pkg::CMD_ENTER, 7'h00, 16'h0000);
      check("mode", {15'h0, secure_mode_o}, 16'h0001);
      check("accel", {15'h0, accel_allowed_o}, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         run(secure_host_pkg::CMD_READ, 7'(i), 16'h0000);
         check("serial", rdata_o, 16'hc000 | 16'(i));
      end
      run(secure_host_pkg::CMD_READ, 7'h7f, 16'h0000);
      check("last word", rdata_o, 16'hffff);
      run(secure_host_pkg::CMD_ENTER, 7'h00, 16'h0000);
      check("reenter err", {15'h0, err_q}, 16'h0001);
      check("mode held", {15'h0, secure_mode_o}, 16'h0001);
      $display("test enter done");
   endtask
   task automatic t_program();
      run(secure_host_pkg::CMD_PROGRAM, 7'h09, 16'h1234);
      check("prog err", {15'h0, err_q}, 16'h0000);
      run(secure_host_pkg::CMD_READ, 7'h09, 16'h0000);
      check("prog word", rdata_o, 16'h1234);
      factory_locked_i <= 1'b1;
      run(secure_host_pkg::CMD_PROGRAM, 7'h09, 16'h0000);
      check("locked err", {15'h0, err_q}, 16'h0001);
      check("indicator", {15'h0, lock_indicator_bit_o}, 16'h0001);
      run(secure_host_pkg::CMD_READ, 7'h09, 16'h0000);
      check("locked word", rdata_o, 16'h1234);
      factory_locked_i <= 1'b0;
      tb_busy <= 1'b1;
      run(secure_host_pkg::CMD_READ, 7'h09, 16'h0000);
      check("busy err", {15'h0, err_q}, 16'h0001);
      check("indicator", {15'h0, lock_indicator_bit_o}, 16'h0000);
      tb_busy <= 1'b0;
      $display("test program done");
   endtask
   task automatic t_exit();
      run(secure_host_pkg::CMD_EXIT, 7'h00, 16'h0000);
      check("exit mode", {15'h0, secure_mode_o}, 16'h0000);
      check("dev mode", {15'h0, i_model.sec_q}, 16'h0000);
      check("accel", {15'h0, accel_allowed_o}, 16'h0001);
      run(secure_host_pkg::CMD_READ, 7'h09, 16'h0000);
      check("array word", rdata_o, 16'h5a53);
      run(secure_host_pkg::CMD_EXIT, 7'h00, 16'h0000);
      check("exit err", {15'h0, err_q}, 16'h0001);
      run(secure_host_pkg::CMD_PROGRAM, 7'h09, 16'h0000);
      check("prog err", {15'h0, err_q}, 16'h0001);
      $display("test exit done");
   endtask
   task automatic t_byte_reset();
      byte_mode_i <= 1'b1;
      run(secure_host_pkg::CMD_ENTER, 7'h00, 16'h0000);
      check("byte enter", {15'h0, i_model.sec_q}, 16'h0001);
      run(secure_host_pkg::CMD_EXIT, 7'h00, 16'h0000);
      check("byte exit", {15'h0, i_model.sec_q}, 16'h0000);
      byte_mode_i <= 1'b0;
      run(secure_host_pkg::CMD_ENTER, 7'h00, 16'h0000);
      run(secure_host_pkg::CMD_RESET, 7'h09, 16'h0000);
      check("reset cmd", {15'h0, secure_mode_o}, 16'h0000);
      run(secure_host_pkg::CMD_ENTER, 7'h00, 16'h0000);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      #1 check("reset mode", {15'h0, secure_mode_o}, 16'h0000);
      run(secure_host_pkg::CMD_READ, 7'h09, 16'h0000);
      check("reset read", rdata_o, 16'h5a53);
      $display("test byte and reset done");
   endtask
   initial begin
      rst_n_i = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_i = secure_host_pkg::CMD_READ;
      cmd_offset_i = 7'h00;
      cmd_wdata_i = 16'h0000;
      byte_mode_i = 1'b0;
      factory_locked_i = 1'b0;
      tb_busy = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      t_enter();
      t_program();
      t_exit();
      t_byte_reset();
      end_sim();
   end
endmodule // secure_sector_host_bench
`default_nettype wire
